// file: hdl/sru_pkg.sv
// status reporting unit constants: bit positions, masks, command codes
// assumes one system clock; numbers mirror the instrument status model
package sru_pkg;

    // ==================================================================
    // status byte bit positions
    localparam int SB_QUES_BIT = 3;
    localparam int SB_MAV_BIT  = 4;
    localparam int SB_ESB_BIT  = 5;
    localparam int SB_RQS_BIT  = 6;
    localparam int SB_OPER_BIT = 7;

    // ==================================================================
    // operation condition bits
    localparam int OP_SETTLE_BIT  = 1;
    localparam int OP_RANGE_BIT   = 2;
    localparam int OP_MEAS_BIT    = 4;
    localparam int OP_PROC_BIT    = 9;
    localparam int OP_HCOPY_BIT   = 10;
    localparam int OP_AVG_BIT     = 11;
    localparam logic [15:0] OP_USED_MASK = 16'h0E16;

    // ==================================================================
    // signal quality condition bits
    localparam int QS_POWER_BIT  = 3;
    localparam int QS_MAXSIG_BIT = 9;
    localparam int QS_DRIFT_BIT  = 10;
    localparam int QS_DELTA_BIT  = 11;
    localparam int QS_WARN_BIT   = 14;
    localparam logic [15:0] QS_USED_MASK = 16'h4E08;

    // ==================================================================
    // status byte: bits 0..2 unused, bit 6 never taken from the enable
    localparam logic [7:0] SB_ENA_MASK = 8'hBF;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_WORD   = 16'h0000;

    // ==================================================================
    // command codes on cmd_i
    localparam logic [3:0] CMD_NONE     = 4'h0;
    localparam logic [3:0] CMD_SPOLL    = 4'h1;
    localparam logic [3:0] CMD_STB_Q    = 4'h2;
    localparam logic [3:0] CMD_ESR_Q    = 4'h3;
    localparam logic [3:0] CMD_SRE_W    = 4'h4;
    localparam logic [3:0] CMD_SRE_Q    = 4'h5;
    localparam logic [3:0] CMD_ESE_W    = 4'h6;
    localparam logic [3:0] CMD_ESE_Q    = 4'h7;
    localparam logic [3:0] CMD_CLS      = 4'h8;
    localparam logic [3:0] CMD_OPER_EV  = 4'h9;
    localparam logic [3:0] CMD_OPER_CON = 4'hA;
    localparam logic [3:0] CMD_QUES_EV  = 4'hB;
    localparam logic [3:0] CMD_QUES_CON = 4'hC;
    localparam logic [3:0] CMD_SEL_W    = 4'hD;

    // select codes for CMD_SEL_W (target in wdata_i[19:16])
    localparam logic [3:0] SEL_OP_ENA  = 4'h0;
    localparam logic [3:0] SEL_OP_PTR  = 4'h1;
    localparam logic [3:0] SEL_OP_NTR  = 4'h2;
    localparam logic [3:0] SEL_QS_ENA  = 4'h3;
    localparam logic [3:0] SEL_QS_PTR  = 4'h4;
    localparam logic [3:0] SEL_QS_NTR  = 4'h5;

    // reset transition filters: positive only
    localparam logic [15:0] PTR_RST = 16'hFFFF;
    localparam logic [15:0] NTR_RST = 16'h0000;

endpackage

// file: hdl/sru_tfilt.sv
// transition filter and event latch for one 16-bit condition register
// assumes conditions already synchronous to clk_i
`timescale 1ns/10ps
module sru_tfilt
    import sru_pkg::*;
#(
    parameter logic [15:0] USED = 16'hFFFF
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // condition and filters
    input  wire logic [15:0] cond_i,
    input  wire logic [15:0] ptr_i,
    input  wire logic [15:0] ntr_i,
    // event read-and-clear, full clear
    input  wire logic        rd_clr_i,
    input  wire logic        clr_i,
    // latched events
    output logic      [15:0] event_o
);

    typedef struct packed {
        logic [15:0] prev;
        logic [15:0] ev;
    } srutf_s;

    srutf_s s_q;
    srutf_s s_d;
    logic [15:0] hit;

    // ==================================================================
    // edge detection
    always_comb begin
        hit = ((cond_i & ~s_q.prev & ptr_i)
            | (~cond_i & s_q.prev & ntr_i)) & USED;
        s_d      = s_q;
        s_d.prev = cond_i & USED;
        // new event wins over a simultaneous clear
        if (rd_clr_i || clr_i) begin
            s_d.ev = hit;
        end else begin
            s_d.ev = s_q.ev | hit;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign event_o = s_q.ev;

endmodule

// file: hdl/sru_top.sv
// status reporting unit: status byte, standard event, operation and
// signal quality registers with masks and service request
// assumes a bus front end decodes commands into one-cycle cmd_i pulses
`timescale 1ns/10ps
module sru_top
    import sru_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // command port
    input  wire logic [3:0]  cmd_i,
    input  wire logic [19:0] wdata_i,
    output logic      [15:0] rdata_o,
    output logic             rvalid_o,
    // operation conditions
    input  wire logic        motor_positioning_flag_i,
    input  wire logic        ranging_i,
    input  wire logic        measuring_i,
    input  wire logic        processing_i,
    input  wire logic        printing_i,
    input  wire logic        averaging_i,
    // signal quality conditions
    input  wire logic        power_high_i,
    input  wire logic        max_signals_i,
    input  wire logic        drift_ref_i,
    input  wire logic        no_delta_ref_i,
    input  wire logic        cmd_warning_i,
    // standard event pulses, bit order opc..pon
    input  wire logic [7:0]  std_event_i,
    // queues
    input  wire logic        out_q_avail_i,
    output logic             err_q_clr_o,
    output logic             opc_req_clr_o,
    // service request
    output logic             srq_o
);

    typedef struct packed {
        logic [1:0][15:0] meta;
        logic [15:0] op_sync;
        logic [15:0] qs_sync;
        logic [7:0]  sre;
        logic [7:0]  ese;
        logic [7:0]  esr;
        logic [15:0] op_ena;
        logic [15:0] op_ptr;
        logic [15:0] op_ntr;
        logic [15:0] qs_ena;
        logic [15:0] qs_ptr;
        logic [15:0] qs_ntr;
        logic        rqs;
        logic        mss_q;
        logic [15:0] rdata;
        logic        rvalid;
        logic        err_clr;
        logic        opc_clr;
    } sru_s;

    sru_s s_q;
    sru_s s_d;

    logic [15:0] op_raw;
    logic [15:0] qs_raw;
    logic [15:0] op_ev;
    logic [15:0] qs_ev;
    logic        op_rd;
    logic        qs_rd;
    logic        cls;
    logic [7:0]  sb;
    logic        mss;

    // ==================================================================
    // condition assembly, unused positions tied low
    always_comb begin
        op_raw = RST_WORD;
        op_raw[OP_SETTLE_BIT] = motor_positioning_flag_i;
        op_raw[OP_RANGE_BIT]  = ranging_i;
        op_raw[OP_MEAS_BIT]   = measuring_i;
        op_raw[OP_PROC_BIT]   = processing_i;
        op_raw[OP_HCOPY_BIT]  = printing_i;
        op_raw[OP_AVG_BIT]    = averaging_i;
        qs_raw = RST_WORD;
        qs_raw[QS_POWER_BIT]  = power_high_i;
        qs_raw[QS_MAXSIG_BIT] = max_signals_i;
        qs_raw[QS_DRIFT_BIT]  = drift_ref_i;
        qs_raw[QS_DELTA_BIT]  = no_delta_ref_i;
        qs_raw[QS_WARN_BIT]   = cmd_warning_i;
    end

    assign cls   = (cmd_i == CMD_CLS);
    assign op_rd = (cmd_i == CMD_OPER_EV);
    assign qs_rd = (cmd_i == CMD_QUES_EV);

    // ==================================================================
    // transition filters
    sru_tfilt #(
        .USED    (OP_USED_MASK)
    ) u_op_filt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .cond_i  (s_q.op_sync),
        .ptr_i   (s_q.op_ptr),
        .ntr_i   (s_q.op_ntr),
        .rd_clr_i(op_rd),
        .clr_i   (cls),
        .event_o (op_ev)
    );

    sru_tfilt #(
        .USED    (QS_USED_MASK)
    ) u_qs_filt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .cond_i  (s_q.qs_sync),
        .ptr_i   (s_q.qs_ptr),
        .ntr_i   (s_q.qs_ntr),
        .rd_clr_i(qs_rd),
        .clr_i   (cls),
        .event_o (qs_ev)
    );

    // ==================================================================
    // status byte: live summaries, unregistered so reads see the present
    always_comb begin
        sb = RST_BYTE;
        sb[SB_QUES_BIT] = |(qs_ev & s_q.qs_ena);
        sb[SB_MAV_BIT]  = out_q_avail_i;
        sb[SB_ESB_BIT]  = |(s_q.esr & s_q.ese);
        sb[SB_OPER_BIT] = |(op_ev & s_q.op_ena);
        mss = |(sb & s_q.sre & SB_ENA_MASK);
    end

    // ==================================================================
    // command handling and state update
    always_comb begin
        s_d         = s_q;
        s_d.meta[0] = op_raw;
        s_d.meta[1] = qs_raw;
        // conditions come from outside logic: two flops before use
        s_d.op_sync = s_q.meta[0];
        s_d.qs_sync = s_q.meta[1];
        s_d.rvalid  = 1'b0;
        s_d.err_clr = 1'b0;
        s_d.opc_clr = 1'b0;
        s_d.mss_q   = mss;
        // request raised on rising master summary
        if (mss && !s_q.mss_q) begin
            s_d.rqs = 1'b1;
        end
        if (!mss) begin
            s_d.rqs = 1'b0;
        end
        s_d.esr = s_q.esr | std_event_i;
        case (cmd_i)
            CMD_SPOLL: begin
                s_d.rdata  = {8'h00, sb | ({7'h00, s_q.rqs} << SB_RQS_BIT)};
                s_d.rvalid = 1'b1;
                // a request rising in the poll cycle stays pending, else it is lost
                s_d.rqs    = mss && !s_q.mss_q;
            end
            CMD_STB_Q: begin
                s_d.rdata  = {8'h00, sb | ({7'h00, mss} << SB_RQS_BIT)};
                s_d.rvalid = 1'b1;
            end
            CMD_ESR_Q: begin
                s_d.rdata  = {8'h00, s_q.esr};
                s_d.rvalid = 1'b1;
                s_d.esr    = std_event_i;
            end
            CMD_SRE_W: begin
                s_d.sre = wdata_i[7:0] & SB_ENA_MASK;
            end
            CMD_SRE_Q: begin
                s_d.rdata  = {8'h00, s_q.sre};
                s_d.rvalid = 1'b1;
            end
            CMD_ESE_W: begin
                s_d.ese = wdata_i[7:0];
            end
            CMD_ESE_Q: begin
                s_d.rdata  = {8'h00, s_q.ese};
                s_d.rvalid = 1'b1;
            end
            CMD_CLS: begin
                s_d.esr     = std_event_i;
                s_d.err_clr = 1'b1;
                s_d.opc_clr = 1'b1;
            end
            CMD_OPER_EV: begin
                s_d.rdata  = op_ev;
                s_d.rvalid = 1'b1;
            end
            CMD_OPER_CON: begin
                s_d.rdata  = s_q.op_sync;
                s_d.rvalid = 1'b1;
            end
            CMD_QUES_EV: begin
                s_d.rdata  = qs_ev;
                s_d.rvalid = 1'b1;
            end
            CMD_QUES_CON: begin
                s_d.rdata  = s_q.qs_sync;
                s_d.rvalid = 1'b1;
            end
            CMD_SEL_W: begin
                case (wdata_i[19:16])
                    SEL_OP_ENA: s_d.op_ena = wdata_i[15:0] & OP_USED_MASK;
                    SEL_OP_PTR: s_d.op_ptr = wdata_i[15:0];
                    SEL_OP_NTR: s_d.op_ntr = wdata_i[15:0];
                    SEL_QS_ENA: s_d.qs_ena = wdata_i[15:0] & QS_USED_MASK;
                    SEL_QS_PTR: s_d.qs_ptr = wdata_i[15:0];
                    SEL_QS_NTR: s_d.qs_ntr = wdata_i[15:0];
                    default:    s_d.op_ena = s_q.op_ena;
                endcase
            end
            default: begin
                s_d.rvalid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q        <= '0;
            s_q.op_ptr <= PTR_RST;
            s_q.qs_ptr <= PTR_RST;
            s_q.op_ntr <= NTR_RST;
            s_q.qs_ntr <= NTR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o       = s_q.rdata;
    assign rvalid_o      = s_q.rvalid;
    assign err_q_clr_o   = s_q.err_clr;
    assign opc_req_clr_o = s_q.opc_clr;
    assign srq_o         = s_q.rqs;

    // ==================================================================
    // checks
    property p_spoll_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cmd_i == CMD_SPOLL) |=> rvalid_o && (!srq_o || $past(mss && !s_q.mss_q));
    endproperty
    a_spoll_clr: assert property (p_spoll_clr) else $error("poll left request");

    property p_stb_keep;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cmd_i == CMD_STB_Q) && srq_o && mss |=> srq_o && rdata_o[SB_RQS_BIT];
    endproperty
    a_stb_keep: assert property (p_stb_keep) else $error("query changed request");

    property p_esr_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cmd_i == CMD_ESR_Q) && (std_event_i == 8'h00) |=> (s_q.esr == 8'h00);
    endproperty
    a_esr_clr: assert property (p_esr_clr) else $error("event reg not cleared");

    property p_esr_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        (std_event_i != 8'h00) |=> ((s_q.esr & $past(std_event_i)) == $past(std_event_i));
    endproperty
    a_esr_set: assert property (p_esr_set) else $error("event lost");

    property p_esb;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cmd_i == CMD_STB_Q) |=> rdata_o[SB_ESB_BIT] == $past(|(s_q.esr & s_q.ese));
    endproperty
    a_esb: assert property (p_esb) else $error("summary bit wrong");

    property p_mav;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cmd_i == CMD_STB_Q) |=> rdata_o[SB_MAV_BIT] == $past(out_q_avail_i);
    endproperty
    a_mav: assert property (p_mav) else $error("message bit wrong");

    property p_unused;
        @(posedge clk_i) disable iff (!rst_n_i)
        ((op_ev & ~OP_USED_MASK) == 16'h0000) && ((qs_ev & ~QS_USED_MASK) == 16'h0000);
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");

    property p_settle_pos;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(s_q.op_sync[OP_SETTLE_BIT]) && s_q.op_ptr[OP_SETTLE_BIT]
            |=> op_ev[OP_SETTLE_BIT];
    endproperty
    a_settle_pos: assert property (p_settle_pos) else $error("no rising event");

    property p_delta_neg;
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(s_q.qs_sync[QS_DELTA_BIT]) && s_q.qs_ntr[QS_DELTA_BIT]
            |=> qs_ev[QS_DELTA_BIT];
    endproperty
    a_delta_neg: assert property (p_delta_neg) else $error("no falling event");

    property p_cls;
        @(posedge clk_i) disable iff (!rst_n_i)
        cls |=> err_q_clr_o && opc_req_clr_o;
    endproperty
    a_cls: assert property (p_cls) else $error("clear status incomplete");

    property p_srq_rise;
        @(posedge clk_i) disable iff (!rst_n_i)
        mss && !s_q.mss_q |=> srq_o;
    endproperty
    a_srq_rise: assert property (p_srq_rise) else $error("request not raised");

    property p_srq_drop;
        @(posedge clk_i) disable iff (!rst_n_i)
        !mss |=> !srq_o;
    endproperty
    a_srq_drop: assert property (p_srq_drop) else $error("request without summary");

    c_spoll: cover property (@(posedge clk_i) srq_o ##1 (cmd_i == CMD_SPOLL));
    c_stb:   cover property (@(posedge clk_i) (cmd_i == CMD_STB_Q) && srq_o);
    c_neg:   cover property (@(posedge clk_i) $fell(s_q.qs_sync[QS_DELTA_BIT]) && s_q.qs_ntr[QS_DELTA_BIT]);
    c_esr:   cover property (@(posedge clk_i) (cmd_i == CMD_ESR_Q) && (s_q.esr != 8'h00));
    c_oper:  cover property (@(posedge clk_i) sb[SB_OPER_BIT]);

endmodule

// file: verification/sru_host_model.sv
// bus controller model: issues one-cycle commands, collects read answers
// assumes the unit answers a read at the edge that takes it, valid until the next edge
`timescale 1ns/10ps
module sru_host_model
    import sru_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // answer from the unit
    input  wire logic        rvalid_i,
    input  wire logic [15:0] rdata_i,
    // command to the unit
    output logic      [3:0]  cmd_o,
    output logic      [19:0] wdata_o
);
    // ==================================================================
    // idle bus
    initial begin
        cmd_o   = CMD_NONE;
        wdata_o = 20'h00000;
    end

    // ==================================================================
    // one transfer; status registers only read through this path
    task automatic xfer(input logic [3:0] cmd, input logic [19:0] wd,
                        output logic [15:0] rd);
        int n;
        n  = 0;
        rd = 16'hFFFF;
        @(negedge clk_i);
        cmd_o   = cmd;
        wdata_o = wd;
        @(negedge clk_i);
        cmd_o   = CMD_NONE;
        // released data no longer shows the last value
        wdata_o = ~wd;
        while (rvalid_i !== 1'b1 && n < 3) begin
            @(negedge clk_i);
            n++;
        end
        if (rvalid_i === 1'b1) begin
            rd = rdata_i;
        end
    endtask
endmodule

// file: verification/sru_top_test.sv
// self-checking bench for the status reporting unit
// assumes the host model drives commands; bench drives conditions and events
`timescale 1ns/10ps
module sru_top_test
    import sru_pkg::*;
;
    // ==================================================================
    // signals
    logic        clk;
    logic        rst_n;
    logic [5:0]  op_c;
    logic [4:0]  qs_c;
    logic [7:0]  std_ev;
    logic        mavail;
    logic [3:0]  cmd;
    logic [19:0] wdata;
    logic [15:0] rdata;
    logic [15:0] rd;
    logic        rvalid;
    logic        err_clr;
    logic        opc_clr;
    logic        srq;
    int          fail_count;
    int          num_checks;
    int          cycles;
    int          clr_cnt;
    localparam int OP_POS [6] = '{OP_SETTLE_BIT, OP_RANGE_BIT, OP_MEAS_BIT,
                                  OP_PROC_BIT, OP_HCOPY_BIT, OP_AVG_BIT};
    localparam int QS_POS [5] = '{QS_POWER_BIT, QS_MAXSIG_BIT, QS_DRIFT_BIT,
                                  QS_DELTA_BIT, QS_WARN_BIT};

    // ==================================================================
    // design and controller
    sru_top i_dut (
        .clk_i                    (clk),
        .rst_n_i                  (rst_n),
        .cmd_i                    (cmd),
        .wdata_i                  (wdata),
        .rdata_o                  (rdata),
        .rvalid_o                 (rvalid),
        .motor_positioning_flag_i (op_c[0]),
        .ranging_i                (op_c[1]),
        .measuring_i              (op_c[2]),
        .processing_i             (op_c[3]),
        .printing_i               (op_c[4]),
        .averaging_i              (op_c[5]),
        .power_high_i             (qs_c[0]),
        .max_signals_i            (qs_c[1]),
        .drift_ref_i              (qs_c[2]),
        .no_delta_ref_i           (qs_c[3]),
        .cmd_warning_i            (qs_c[4]),
        .std_event_i              (std_ev),
        .out_q_avail_i            (mavail),
        .err_q_clr_o              (err_clr),
        .opc_req_clr_o            (opc_clr),
        .srq_o                    (srq)
    );

    sru_host_model i_host (
        .clk_i    (clk),
        .rvalid_i (rvalid),
        .rdata_i  (rdata),
        .cmd_o    (cmd),
        .wdata_o  (wdata)
    );

    // ==================================================================
    // clock, timeout, clear pulse counter
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (err_clr === 1'b1 && opc_clr === 1'b1) begin
            clr_cnt++;
        end
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    // ==================================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task automatic rd_chk(input logic [3:0] c, input logic [15:0] exp);
        i_host.xfer(c, 20'h00000, rd);
        check(rd, exp);
    endtask

    task automatic wr(input logic [3:0] c, input logic [19:0] wd);
        i_host.xfer(c, wd, rd);
    endtask

    task automatic pulse(input int i);
        @(negedge clk);
        std_ev = 8'h01 << i;
        @(negedge clk);
        std_ev = 8'h00;
    endtask

    task automatic settle();
        repeat (5) @(negedge clk);
    endtask

    task automatic results();
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==================================================================
    // scenarios
    task automatic t_reset_masks();
        rd_chk(CMD_SRE_Q, 16'h0000);
        rd_chk(CMD_ESE_Q, 16'h0000);
        rd_chk(CMD_STB_Q, 16'h0000);
        rd_chk(CMD_OPER_CON, 16'h0000);
        wr(CMD_ESE_W, 20'h0003C);
        rd_chk(CMD_ESE_Q, 16'h003C);
        // request bit can never be enabled
        wr(CMD_SRE_W, 20'h000FF);
        rd_chk(CMD_SRE_Q, 16'h00BF);
    endtask

    task automatic t_std_events();
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            rd_chk(CMD_ESR_Q, 16'h0001 << i);
            rd_chk(CMD_ESR_Q, 16'h0000);
        end
    endtask

    task automatic t_service();
        wr(CMD_SRE_W, 20'h00020);
        pulse(0);
        rd_chk(CMD_STB_Q, 16'h0000);
        check({15'h0000, srq}, 16'h0000);
        pulse(4);
        settle();
        check({15'h0000, srq}, 16'h0001);
        rd_chk(CMD_STB_Q, 16'h0060);
        check({15'h0000, srq}, 16'h0001);
        rd_chk(CMD_SPOLL, 16'h0060);
        check({15'h0000, srq}, 16'h0000);
        rd_chk(CMD_SPOLL, 16'h0020);
        rd_chk(CMD_ESR_Q, 16'h0011);
        rd_chk(CMD_STB_Q, 16'h0000);
    endtask

    task automatic t_conditions();
        wr(CMD_SEL_W, {SEL_OP_ENA, 16'hFFFF});
        wr(CMD_SEL_W, {SEL_QS_ENA, 16'hFFFF});
        for (int i = 0; i < 6; i++) begin
            op_c = 6'h01 << i;
            settle();
            rd_chk(CMD_OPER_CON, 16'h0001 << OP_POS[i]);
            rd_chk(CMD_STB_Q, 16'h0080);
            rd_chk(CMD_OPER_EV, 16'h0001 << OP_POS[i]);
            rd_chk(CMD_STB_Q, 16'h0000);
        end
        op_c = 6'h00;
        for (int i = 0; i < 5; i++) begin
            qs_c = 5'h01 << i;
            settle();
            rd_chk(CMD_QUES_CON, 16'h0001 << QS_POS[i]);
            rd_chk(CMD_STB_Q, 16'h0008);
            rd_chk(CMD_QUES_EV, 16'h0001 << QS_POS[i]);
        end
        qs_c = 5'h00;
        settle();
        rd_chk(CMD_QUES_EV, 16'h0000);
    endtask

    task automatic t_negative();
        wr(CMD_SEL_W, {SEL_OP_PTR, 16'h0000});
        wr(CMD_SEL_W, {SEL_OP_NTR, 16'hFFFF});
        wr(CMD_SEL_W, {SEL_QS_PTR, 16'h0000});
        wr(CMD_SEL_W, {SEL_QS_NTR, 16'hFFFF});
        op_c = 6'h04;
        qs_c = 5'h08;
        settle();
        rd_chk(CMD_OPER_EV, 16'h0000);
        rd_chk(CMD_QUES_EV, 16'h0000);
        op_c = 6'h00;
        qs_c = 5'h00;
        settle();
        rd_chk(CMD_OPER_EV, 16'h0010);
        rd_chk(CMD_QUES_EV, 16'h0800);
    endtask

    task automatic t_mav_clear();
        mavail = 1'b1;
        rd_chk(CMD_STB_Q, 16'h0010);
        mavail = 1'b0;
        pulse(5);
        clr_cnt = 0;
        wr(CMD_CLS, 20'h00000);
        check(16'(clr_cnt), 16'h0001);
        rd_chk(CMD_ESR_Q, 16'h0000);
        rd_chk(CMD_STB_Q, 16'h0000);
    endtask

    // ==================================================================
    // main sequence
    initial begin
        rst_n      = 1'b0;
        op_c       = 6'h00;
        qs_c       = 5'h00;
        std_ev     = 8'h00;
        mavail     = 1'b0;
        fail_count = 0;
        num_checks = 0;
        cycles     = 0;
        clr_cnt    = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_reset_masks();
        t_std_events();
        t_service();
        t_conditions();
        t_negative();
        t_mav_clear();
        results();
    end
endmodule
